/* logic/lrf_refresh_fetch.sv */
// LCD refresh fetch: register slave, address walk, CPU rotation, FIFO gate.
// Assumes a single-master AHB-Lite bus and same-clock panel and memory logic.
`timescale 1ns/100ps

// How it works
// - Rotation field 10b walks fetch addresses downward
// - 180-degree mode leaves CPU addresses untouched
// - Rotation field 11b rotates CPU addresses 270 degrees
// - 180-degree fetch works at 4, 8, 16 bpp
// - 90/270 CPU rotation only at 8, 16 bpp
// - 180 start and pixel panning pan reversed
// - Start plus one stride scrolls one line
// - 270 start steps of one stride pan one pixel
// - 270 start and panning steps scroll lines
// - Overlay and cursor accesses are never rotated
// - Display buffer maps linearly on 21 address bits
// - Nonzero threshold register becomes FIFO high threshold
// - Zero threshold picks per-depth default
// - Threshold sets display fetch request rate
module lrf_refresh_fetch
    import lrf_pkg::*;
#(
    parameter int FIFO_DEPTH = 64
) (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        frameStart,
    output logic             fetchReq,
    input  wire logic        fetchAck,
    output logic [19:0]      fetchAddr,
    input  wire logic        wordTake,
    output logic [3:0]       pixelPan,
    input  wire logic [20:0] cpuAddr,
    input  wire logic        cpuOverlaySel,
    output logic [20:0]      cpuMemAddr
);
    localparam int FILL_W = $clog2(FIFO_DEPTH + 1);

    typedef struct packed {
        lrf_rot_t          rot;
        lrf_bpp_t          bpp;
        logic [3:0]        pan;
        logic [23:0]       start;
        logic [15:0]       stride;
        logic [9:0]        lineWords;
        logic [9:0]        panelLines;
        logic [7:0]        thrReg;
        lrf_fsm_t          fsm;
        logic [23:0]       lineBase;
        logic [23:0]       curAddr;
        logic [9:0]        wordCnt;
        logic [9:0]        lineCnt;
        logic [FILL_W-1:0] fill;
        logic [3:0]        panOut;
        logic [20:0]       memAddr;
        logic              dpValid;
        logic              dpWrite;
        logic [7:0]        dpIdx;
        logic [31:0]       rdata;
    } lrf_state_t;

    lrf_state_t st;
    lrf_state_t next_st;

    lrf_cpu_if cpuPath ();

    logic [6:0]  activeThr;
    logic        fillBelow;
    logic        fetchStep;
    logic        takeWord;
    logic        addrPhase;
    logic        regHit;
    logic [7:0]  addrIdx;
    logic [23:0] strideExt;
    logic [3:0]  panMask;

    assign cpuPath.cpuAddr    = cpuAddr;
    assign cpuPath.rot        = st.rot;
    assign cpuPath.bpp        = st.bpp;
    assign cpuPath.overlaySel = cpuOverlaySel;

    lrf_cpu_rotator rotator_i (
        .cpu (cpuPath.rotator)
    );

    function automatic logic [31:0] readMux(lrf_state_t s, logic [7:0] idx,
                                            logic [6:0] thr);
        logic [31:0] v;
        v = 32'h00000000;
        case (idx)
            IDX_CTRL: begin
                v[CTRL_ROT_LSB +: 2] = s.rot;
                v[CTRL_BPP_LSB +: 2] = s.bpp;
                v[CTRL_PAN_LSB +: 4] = s.pan;
            end
            IDX_STATUS: begin
                v[STAT_ACTIVE_BIT] = (s.fsm == FS_ACTIVE);
                v[STAT_UNSUP_BIT]  = s.rot[0] && (s.bpp == BPP4);
                v[STAT_FILL_LSB +: FILL_W] = s.fill;
                v[STAT_THR_LSB +: 7] = thr;
            end
            IDX_START_LO:    v[7:0] = s.start[7:0];
            IDX_START_MID:   v[7:0] = s.start[15:8];
            IDX_START_HI:    v[7:0] = s.start[23:16];
            IDX_STRIDE_LO:   v[7:0] = s.stride[7:0];
            IDX_STRIDE_HI:   v[7:0] = s.stride[15:8];
            IDX_LINE_WORDS:  v[9:0] = s.lineWords;
            IDX_PANEL_LINES: v[9:0] = s.panelLines;
            IDX_FIFO_THR:    v[7:0] = s.thrReg;
            default:         v = 32'h00000000;
        endcase
        return v;
    endfunction

    always_comb begin
        next_st = st;

        // Active threshold from the registered threshold and depth
        if (st.thrReg != 8'h00) begin
            activeThr = st.thrReg[6:0];
        end else begin
            case (st.bpp)
                BPP4:    activeThr = THR_DEF_4BPP;
                BPP8:    activeThr = THR_DEF_8BPP;
                default: activeThr = THR_DEF_16BPP;
            endcase
        end

        // Higher threshold keeps requests open longer, more bandwidth
        fillBelow = {{(32-FILL_W){1'b0}}, st.fill} < {25'h0, activeThr};
        fetchReq  = (st.fsm == FS_ACTIVE) && fillBelow;
        fetchStep = fetchReq && fetchAck;
        takeWord  = wordTake && (st.fill != '0);
        strideExt = {8'h00, st.stride};

        // Data phase: register writes land here
        if (st.dpValid && st.dpWrite) begin
            case (st.dpIdx)
                IDX_CTRL: begin
                    next_st.rot = lrf_rot_t'(hwdata[CTRL_ROT_LSB +: 2]);
                    next_st.bpp = lrf_bpp_t'(hwdata[CTRL_BPP_LSB +: 2]);
                    next_st.pan = hwdata[CTRL_PAN_LSB +: 4];
                end
                IDX_START_LO:    next_st.start[7:0]   = hwdata[7:0];
                IDX_START_MID:   next_st.start[15:8]  = hwdata[7:0];
                IDX_START_HI:    next_st.start[23:16] = hwdata[7:0];
                IDX_STRIDE_LO:   next_st.stride[7:0]  = hwdata[7:0];
                IDX_STRIDE_HI:   next_st.stride[15:8] = hwdata[7:0];
                IDX_LINE_WORDS:  next_st.lineWords    = hwdata[9:0];
                IDX_PANEL_LINES: next_st.panelLines   = hwdata[9:0];
                IDX_FIFO_THR:    next_st.thrReg       = hwdata[7:0];
                default:         next_st.dpIdx        = st.dpIdx;
            endcase
        end

        // Address phase; unmapped indices read zero and drop writes
        addrPhase = hsel && htrans[1] && hready;
        addrIdx   = haddr[9:2];
        regHit    = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
        next_st.dpValid = addrPhase && regHit;
        next_st.dpWrite = hwrite;
        next_st.dpIdx   = addrIdx;
        if (addrPhase && !hwrite) begin
            // Read sees a write committed at this same edge, except in the status threshold field
            next_st.rdata = regHit ? readMux(next_st, addrIdx, activeThr)
                                   : 32'h00000000;
        end

        // FIFO fill count
        if (fetchStep && !takeWord) begin
            next_st.fill = st.fill + 1'b1;
        end else if (!fetchStep && takeWord) begin
            next_st.fill = st.fill - 1'b1;
        end

        // Refresh address walk; reversed for 180 and 270
        case (st.fsm)
            FS_IDLE: begin
                next_st.fsm = FS_IDLE;
            end
            FS_ACTIVE: begin
                if (fetchStep) begin
                    if (st.wordCnt == st.lineWords) begin
                        next_st.wordCnt = 10'h000;
                        if (st.lineCnt == st.panelLines) begin
                            next_st.fsm = FS_IDLE;
                        end else begin
                            next_st.lineCnt = st.lineCnt + 10'h001;
                            if (st.rot[1]) begin
                                next_st.lineBase = st.lineBase
                                                 - strideExt;
                            end else begin
                                next_st.lineBase = st.lineBase + strideExt;
                            end
                            next_st.curAddr = next_st.lineBase;
                        end
                    end else begin
                        next_st.wordCnt = st.wordCnt + 10'h001;
                        if (st.rot[1]) begin
                            next_st.curAddr = st.curAddr
                                            - 24'h000001;
                        end else begin
                            next_st.curAddr = st.curAddr + 24'h000001;
                        end
                    end
                end
            end
            default: begin
                next_st.fsm = FS_IDLE;
            end
        endcase

        // New frame restarts the walk from the start address
        if (frameStart) begin
            next_st.fsm      = FS_ACTIVE;
            next_st.lineBase = st.start;
            next_st.curAddr  = st.start;
            next_st.wordCnt  = 10'h000;
            next_st.lineCnt  = 10'h000;
        end

        // Pixel panning runs the other way under reversed refresh
        case (st.bpp)
            BPP4:    panMask = PAN_MASK_4BPP;
            BPP8:    panMask = PAN_MASK_8BPP;
            default: panMask = PAN_MASK_16BPP;
        endcase
        next_st.panOut = st.rot[1] ? (~st.pan & panMask)
                                   : (st.pan & panMask);

        // CPU path: 180 never touches it, overlay never rotated
        next_st.memAddr = cpuPath.memAddr;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st            <= '0;
            st.rot        <= RST_ROT;
            st.bpp        <= RST_BPP;
            st.pan        <= RST_PAN;
            st.start      <= RST_START;
            st.stride     <= RST_STRIDE;
            st.lineWords  <= RST_LINE_WORDS;
            st.panelLines <= RST_PANEL_LINES;
            st.thrReg     <= RST_FIFO_THR;
            st.fsm        <= FS_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign hrdata     = st.rdata;
    assign fetchAddr  = st.curAddr[19:0];
    assign pixelPan   = st.panOut;
    assign cpuMemAddr = st.memAddr;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    rev_fetch_step_a: assert property (
        (st.fsm == FS_ACTIVE && fetchStep && st.rot == ROT_180
         && st.wordCnt != st.lineWords && !frameStart)
        |=> st.curAddr == $past(st.curAddr) - 24'h000001)
        else $error("180 fetch did not step down one word");

    cpu_plain_180_a: assert property (
        (st.rot == ROT_180) |=> cpuMemAddr == $past(cpuAddr))
        else $error("180 mode altered a CPU address");

    cpu_rot270_a: assert property (
        (st.rot == ROT_270 && st.bpp == BPP16 && !cpuOverlaySel)
        |=> cpuMemAddr == {$past(cpuAddr[10:1]), ~$past(cpuAddr[20:11]),
                           $past(cpuAddr[0])})
        else $error("270 CPU address transform wrong");

    no_rot_4bpp_a: assert property (
        (st.rot[0] && st.bpp == BPP4) |=> cpuMemAddr == $past(cpuAddr))
        else $error("4 bpp access was rotated");

    overlay_plain_a: assert property (
        cpuOverlaySel |=> cpuMemAddr == $past(cpuAddr))
        else $error("overlay access was rotated");

    thr_prog_a: assert property (
        (st.thrReg != 8'h00) && fetchReq
        |-> {25'h0, st.thrReg[6:0]} > {{(32-FILL_W){1'b0}}, st.fill})
        else $error("programmed threshold not honoured");

    thr_default_a: assert property (
        (st.thrReg == 8'h00 && st.bpp == BPP8 && st.fsm == FS_ACTIVE
         && st.fill <= FILL_W'(32)) |-> fetchReq)
        else $error("8 bpp default threshold not applied");

    fetch_stop_a: assert property (
        ({{(32-FILL_W){1'b0}}, st.fill} >= {25'h0, activeThr}) |-> !fetchReq)
        else $error("fetch requested at or above threshold");

    rev_line_a: assert property (
        (fetchStep && st.rot[1] && st.wordCnt == st.lineWords
         && st.lineCnt != st.panelLines && !frameStart)
        |=> st.curAddr == $past(st.lineBase) - {8'h00, $past(st.stride)})
        else $error("reversed line step is not one stride");

    pan_reverse_a: assert property (
        (st.rot == ROT_180 && st.bpp == BPP4)
        |=> pixelPan == (~$past(st.pan) & PAN_MASK_4BPP))
        else $error("180 pixel panning not reversed");

    linear_map_a: assert property (
        (st.rot == ROT_NONE) |=> cpuMemAddr == $past(cpuAddr))
        else $error("unrotated CPU mapping not linear");
endmodule

/* logic/lrf_pkg.sv */
// Constants and types for the LCD rotated refresh fetch block.
// Assumes a 32-bit AHB-Lite register bus, one word per register index.
package lrf_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL        = 8'h40;
    localparam logic [7:0] IDX_STATUS      = 8'h41;
    localparam logic [7:0] IDX_START_LO    = 8'h42;
    localparam logic [7:0] IDX_START_MID   = 8'h43;
    localparam logic [7:0] IDX_START_HI    = 8'h44;
    localparam logic [7:0] IDX_STRIDE_LO   = 8'h46;
    localparam logic [7:0] IDX_STRIDE_HI   = 8'h47;
    localparam logic [7:0] IDX_LINE_WORDS  = 8'h48;
    localparam logic [7:0] IDX_PANEL_LINES = 8'h49;
    localparam logic [7:0] IDX_FIFO_THR    = 8'h4A;

    // Control register fields
    localparam int CTRL_ROT_LSB = 0;
    localparam int CTRL_BPP_LSB = 2;
    localparam int CTRL_PAN_LSB = 4;

    // Status register fields
    localparam int STAT_ACTIVE_BIT = 0;
    localparam int STAT_UNSUP_BIT  = 1;
    localparam int STAT_FILL_LSB   = 8;
    localparam int STAT_THR_LSB    = 16;

    typedef enum logic [1:0] {
        ROT_NONE = 2'h0,
        ROT_90   = 2'h1,
        ROT_180  = 2'h2,
        ROT_270  = 2'h3
    } lrf_rot_t;

    typedef enum logic [1:0] {
        BPP4  = 2'h0,
        BPP8  = 2'h1,
        BPP16 = 2'h2
    } lrf_bpp_t;

    typedef enum logic [1:0] {
        FS_IDLE   = 2'b01,
        FS_ACTIVE = 2'b10
    } lrf_fsm_t;

    // Reset values
    localparam lrf_rot_t    RST_ROT         = ROT_NONE;
    localparam lrf_bpp_t    RST_BPP         = BPP8;
    localparam logic [3:0]  RST_PAN         = 4'h0;
    localparam logic [23:0] RST_START       = 24'h000000;
    localparam logic [15:0] RST_STRIDE      = 16'h0000;
    localparam logic [9:0]  RST_LINE_WORDS  = 10'h000;
    localparam logic [9:0]  RST_PANEL_LINES = 10'h000;
    localparam logic [7:0]  RST_FIFO_THR    = 8'h00;

    // Default high thresholds used while the threshold register is zero
    localparam logic [6:0] THR_DEF_4BPP  = 7'h11;
    localparam logic [6:0] THR_DEF_8BPP  = 7'h21;
    localparam logic [6:0] THR_DEF_16BPP = 7'h23;

    // Pixel panning masks per depth (pixels per 16-bit word, minus one)
    localparam logic [3:0] PAN_MASK_4BPP  = 4'h3;
    localparam logic [3:0] PAN_MASK_8BPP  = 4'h1;
    localparam logic [3:0] PAN_MASK_16BPP = 4'h0;

endpackage

/* logic/lrf_cpu_if.sv */
// CPU display-buffer address path between the top and the rotator.
// Assumes all members are driven on the core clock domain.
`timescale 1ns/100ps
interface lrf_cpu_if
    import lrf_pkg::*;
();
    logic [20:0] cpuAddr;
    logic [20:0] memAddr;
    lrf_rot_t    rot;
    lrf_bpp_t    bpp;
    logic        overlaySel;

    modport rotator (
        input  cpuAddr,
        input  rot,
        input  bpp,
        input  overlaySel,
        output memAddr
    );
    modport ctrl (
        output cpuAddr,
        output rot,
        output bpp,
        output overlaySel,
        input  memAddr
    );
endinterface

/* logic/lrf_cpu_rotator.sv */
// Combinational address rotation for CPU display-buffer accesses.
// Assumes a 1024 x 1024 pixel virtual window set up by software.
`timescale 1ns/100ps
module lrf_cpu_rotator
    import lrf_pkg::*;
(
    lrf_cpu_if.rotator cpu
);
    logic [9:0] colIdx;
    logic [9:0] rowIdx;

    always_comb begin
        colIdx = 10'h000;
        rowIdx = 10'h000;
        cpu.memAddr = cpu.cpuAddr;
        // Overlay memory and 4 bpp always pass straight through
        if (!cpu.overlaySel && cpu.rot[0] && cpu.bpp != BPP4) begin
            if (cpu.bpp == BPP8) begin
                colIdx = cpu.cpuAddr[9:0];
                rowIdx = cpu.cpuAddr[19:10];
                if (cpu.rot == ROT_270) begin
                    cpu.memAddr = {cpu.cpuAddr[20], colIdx, ~rowIdx};
                end else begin
                    cpu.memAddr = {cpu.cpuAddr[20], ~colIdx, rowIdx};
                end
            end else begin
                colIdx = cpu.cpuAddr[10:1];
                rowIdx = cpu.cpuAddr[20:11];
                if (cpu.rot == ROT_270) begin
                    cpu.memAddr = {colIdx, ~rowIdx, cpu.cpuAddr[0]};
                end else begin
                    cpu.memAddr = {~colIdx, rowIdx, cpu.cpuAddr[0]};
                end
            end
        end
    end
endmodule

/* verif/lrf_panel_model.sv */
// Stand-in for the panel pipe and the memory behind the fetch link.
// Assumes the bench steers its enables just after rising edges.
`timescale 1ns/100ps
module lrf_panel_model (
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic fetchReq,
    input  wire logic ackEn,
    input  wire logic takeEn,
    output logic      fetchAck,
    output logic      wordTake
);
    // Memory may stall; an ack only ever answers a live request
    assign fetchAck = fetchReq & ackEn;
    always_ff @(posedge core_clk) begin
        wordTake <= takeEn & ~sys_rst;
    end
endmodule

/* verif/tb_lrf_refresh_fetch.sv */
// Self-checking bench for the refresh fetch block.
// Assumes one AHB-Lite slave and a random stalling panel model.
`timescale 1ns/100ps
module tb_lrf_refresh_fetch;
    import lrf_pkg::*;
    logic        core_clk, sys_rst, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        frameStart, fetchReq, fetchAck, wordTake, ackEn, takeEn;
    logic [19:0] fetchAddr;
    logic [3:0]  pixelPan;
    logic [20:0] cpuAddr, cpuMemAddr;
    logic        cpuOverlaySel;
    int          failures, nCompared, cycles, fill, thrExp;
    int          strideV, startV, offV;
    int          seed;
    bit          expActive;
    logic [19:0] addrQ[$];
    logic [31:0] rv;

    assign hready = hreadyout;

    lrf_refresh_fetch DUT (
        .core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .frameStart(frameStart),
        .fetchReq(fetchReq), .fetchAck(fetchAck), .fetchAddr(fetchAddr),
        .wordTake(wordTake), .pixelPan(pixelPan), .cpuAddr(cpuAddr),
        .cpuOverlaySel(cpuOverlaySel), .cpuMemAddr(cpuMemAddr)
    );

    lrf_panel_model PANEL (
        .core_clk(core_clk), .sys_rst(sys_rst), .fetchReq(fetchReq),
        .ackEn(ackEn), .takeEn(takeEn), .fetchAck(fetchAck),
        .wordTake(wordTake)
    );

    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, seen);
            failures++;
        end
    endtask

    task automatic end_of_test();
        if (failures == 0 && nCompared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // One single word transfer; waits on hready, never on a fixed count
    task automatic ahb(logic wr, logic [7:0] idx, logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge core_clk);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= 3'h2;
        do @(posedge core_clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge core_clk); while (hready !== 1'b1);
        rd = hrdata;
        chk("hresp", hresp, 1'b0);
    endtask

    task automatic wr(logic [7:0] idx, logic [31:0] v);
        logic [31:0] d;
        ahb(1'b1, idx, v, d);
    endtask

    task automatic rd(logic [7:0] idx, logic [31:0] m, logic [31:0] exp);
        logic [31:0] d;
        ahb(1'b0, idx, 32'h0, d);
        chk("hrdata", d & m, exp);
    endtask

    function automatic logic [20:0] rotx(logic [1:0] r, logic [1:0] b,
                                         logic ov, logic [20:0] a);
        if (!r[0] || b == 2'h0 || ov) return a;
        if (b == 2'h1) return r[1] ? {a[20], a[9:0], ~a[19:10]}
                                   : {a[20], ~a[9:0], a[19:10]};
        return r[1] ? {a[10:1], ~a[20:11], a[0]}
                    : {~a[10:1], a[20:11], a[0]};
    endfunction

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        ackEn  <= 1'($random(seed));
        takeEn <= ($random(seed) & 3) == 0;
        cycles++;
        if (cycles == 20000) begin
            failures++;
            end_of_test();
        end
    end

    // Reference fetch model, sampled where everything has settled
    always @(negedge core_clk) begin
        if (sys_rst) begin
            fill = 0;
            expActive = 0;
        end else begin
            chk("fetchReq", fetchReq, expActive && fill < thrExp);
            if (wordTake && fill > 0) fill--;
            if (fetchReq && fetchAck) begin
                chk("fetchAddr", fetchAddr, addrQ.pop_front());
                fill++;
            end
            if (addrQ.size() == 0) expActive = 0;
            if (frameStart) expActive = 1;
        end
    end

    initial begin
        seed = 32'hE717C7FD;
        {hsel, hwrite, frameStart, cpuOverlaySel} = '0;
        {haddr, hwdata, htrans, hsize, cpuAddr} = '0;
        thrExp = 8'h21;
        sys_rst = 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(IDX_CTRL, 32'hFF, 32'h04);
        rd(IDX_FIFO_THR, 32'hFFFFFFFF, 32'h0);
        wr(8'h45, 32'h5A);
        rd(8'h45, 32'hFFFFFFFF, 32'h0);
        for (int b = 0; b < 3; b++) begin
            wr(IDX_CTRL, b << 2);
            rd(IDX_STATUS, 32'h7F0000, (b == 0 ? 32'h11 : b == 1 ? 32'h21
                                        : 32'h23) << 16);
        end
        wr(IDX_FIFO_THR, 32'h3B);
        rd(IDX_FIFO_THR, 32'hFF, 32'h3B);
        rd(IDX_STATUS, 32'h7F0000, 32'h3B0000);
        // 8 bpp, 3 words (6 pixels) a line, 2 lines
        wr(IDX_LINE_WORDS, 32'h02);
        wr(IDX_PANEL_LINES, 32'h01);
        for (int r = 0; r < 4; r++) begin
            strideV = r == 3 ? 512 : 8;
            startV  = r == 2 ? strideV * 2 - (strideV - 3) - 1
                    : r == 3 ? strideV * 2 - 1
                    : 32'h12345;
            // Default threshold once, then a small one so the gate closes
            wr(IDX_FIFO_THR, r == 0 ? 32'h00 : 32'h04);
            thrExp = r == 0 ? 32'h21 : 4;
            wr(IDX_CTRL, 32'h04 | r);
            wr(IDX_STRIDE_LO, strideV & 32'hFF);
            wr(IDX_STRIDE_HI, strideV >> 8);
            wr(IDX_START_LO, startV & 32'hFF);
            wr(IDX_START_MID, (startV >> 8) & 32'hFF);
            wr(IDX_START_HI, startV >> 16);
            rd(IDX_START_MID, 32'hFF, (startV >> 8) & 32'hFF);
            for (int l = 0; l < 2; l++) begin
                for (int w = 0; w < 3; w++) begin
                    offV = l * strideV + w;
                    addrQ.push_back(20'(r[1] ? startV - offV
                                             : startV + offV));
                end
            end
            @(posedge core_clk);
            frameStart <= 1'b1;
            @(posedge core_clk);
            frameStart <= 1'b0;
            while (addrQ.size() > 0) @(posedge core_clk);
            repeat (3) @(posedge core_clk);
        end
        for (int r = 0; r < 4; r++) begin
            for (int b = 0; b < 4; b++) begin
                wr(IDX_CTRL, (b << 2) | r);
                rd(IDX_STATUS, 32'h2, {r[0] && b == 0, 1'b0});
                for (int ov = 0; ov < 2; ov++) begin
                    rv = $random(seed);
                    @(posedge core_clk);
                    cpuAddr <= rv[20:0];
                    cpuOverlaySel <= ov[0];
                    @(posedge core_clk);
                    @(negedge core_clk);
                    chk("cpuMemAddr", cpuMemAddr, rotx(r[1:0], b[1:0],
                        ov[0], rv[20:0]));
                end
            end
        end
        for (int b = 0; b < 3; b++) begin
            rv = $random(seed);
            wr(IDX_CTRL, {rv[3:0], b[1:0], 2'h2});
            repeat (2) @(posedge core_clk);
            @(negedge core_clk);
            chk("pixelPan", pixelPan, ~rv[3:0] & (b == 0 ? 4'h3 : b == 1
                                      ? 4'h1 : 4'h0));
        end
        end_of_test();
    end
endmodule
